// ===== hdl/ovt_timing.sv
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1: Instant mode trips together with start
// R2: Fixed delay trips after continuous pick-up
// R3: Inverse delay is dial over ratio-power minus one
// R4: Delay type 1 fixed, 2 inverse, default fixed
// R5: Fixed delay 5 ms steps, default 40 ms
// R6: Zero fixed delay behaves as instant
// R7: Dial 0.01 steps, default 0.05
// R8: Exponent 0.01 steps, default 1.00
// R9: Release delay 5 ms steps, default 60 ms
// R10: Delayed release holds start until expiry
// R11: Timer clears after full release, else immediately
// R12: Optionally keep timing through release window
// R13: No trip unless pick-up returns in window
// R14: ON and OFF events for three outputs
// R15: Per-event mask selects ON, OFF or both
// R16: Four stages, events tagged with stage
// R17: Events carry time stamp and process data
// R18: Twelve-deep circular record per stage
// R19: Records only on ON events
// R20: Record holds time, event, fault, voltages, remaining, group
// R21: Pick-up above threshold, release below 97 percent
// R22: Blocking at pick-up gives blocked, not start
// R23: Timers advance on 5 ms ticks
// R24: Remaining time is delay minus timer, floored zero
module ovt_timing #(
  parameter int TICK_CYCLES = ovt_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] measured_voltage,
  input wire logic [3:0] blocking_in,
  input wire logic [31:0] time_stamp,
  input wire logic [2:0] fault_type,
  input wire logic [2:0] setting_group,
  output logic [3:0] start_out,
  output logic [3:0] trip_out,
  output logic [3:0] blocked_out,
  output logic evt_valid,
  output logic [1:0] evt_stage,
  output logic [2:0] evt_code,
  output logic [31:0] evt_time,
  output logic [15:0] evt_voltage
);
  localparam int NS = ovt_pkg::NUM_STAGES;
  localparam int NE = ovt_pkg::EVT_KINDS;
  localparam int TW = ovt_pkg::TW;
  localparam int VW = ovt_pkg::VW;
  localparam logic [ovt_pkg::TCW-1:0] TICK_LAST = ovt_pkg::TCW'(TICK_CYCLES - 1);
  localparam logic [4:0] SCAN_LAST = 5'(NS * NE - 1);

  // Inverse-time delay in ticks, log2/exp2 by piecewise-linear approximation
  function automatic logic [TW-1:0] inverse_delay_mode_ticks(input logic [VW-1:0] vm, input logic [VW-1:0] vs,
                                                input logic [12:0] k, input logic [11:0] a);
    logic [31:0] ratio;
    logic [31:0] norm;
    logic [4:0] msb;
    logic [16:0] lg;
    logic [31:0] y;
    logic [47:0] pw;
    logic [47:0] num;
    logic [47:0] q;
    ratio = 32'({vm, 12'h000}) / 32'((vs == 16'h0000) ? 16'h0001 : vs);
    msb = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (ratio[i]) msb = 5'(i);
    end
    norm = ratio << (5'd31 - msb);
    lg = {5'(msb - 5'(ovt_pkg::RATIO_FRAC)), norm[30:19]};
    y = (32'(lg) * 32'(a)) / 32'(ovt_pkg::EXP_SCALE);
    pw = 48'({1'b1, y[11:0]}) << y[16:12];
    num = 48'(k) * 48'(ovt_pkg::DIAL_TICKS) << ovt_pkg::RATIO_FRAC;
    q = 48'(ovt_pkg::MAX_TICKS);
    if (ratio[31:ovt_pkg::RATIO_FRAC] == 20'h00000) begin
      inverse_delay_mode_ticks = ovt_pkg::MAX_TICKS;
    end else if (y[31:17] != 15'h0000) begin
      inverse_delay_mode_ticks = TW'(0);
    end else begin
      if (pw > 48'h001000) q = num / (pw - 48'h001000);
      inverse_delay_mode_ticks = (q > 48'(ovt_pkg::MAX_TICKS)) ? ovt_pkg::MAX_TICKS : q[TW-1:0];
    end
  endfunction : inverse_delay_mode_ticks

  // Program-cycle tick
  logic [ovt_pkg::TCW-1:0] tick_cnt;
  logic tick;
  always_ff @(posedge clk) begin
    if (reset) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else if (tick_cnt == TICK_LAST) begin
      tick_cnt <= '0;
      tick <= 1'b1; // R23
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      tick <= 1'b0;
    end
  end

  // Voltage history, newest first, one sample per tick
  logic [VW-1:0] hist [ovt_pkg::HIST_DEPTH];
  genvar h;
  generate
    for (h = 0; h < ovt_pkg::HIST_DEPTH; h++) begin : g_hist
      always_ff @(posedge clk) begin
        if (reset) hist[h] <= '0;
        else if (tick) hist[h] <= (h == 0) ? measured_voltage : hist[(h == 0) ? 0 : h - 1];
      end
    end
  endgenerate

  logic [VW+1:0] sum_pre;
  logic [VW-1:0] avg_pre;
  always_comb begin
    sum_pre = '0;
    for (int i = 0; i < ovt_pkg::AVG_DEPTH; i++) sum_pre = sum_pre + (VW+2)'(hist[i]);
    avg_pre = VW'(sum_pre >> ovt_pkg::AVG_SHIFT); // R20
  end

  // APB access
  logic [1:0] sel_stage;
  logic [5:0] sel_off;
  logic unmapped;
  logic wr_en;
  logic [31:0] stage_rd [NS];
  assign sel_stage = paddr[7:ovt_pkg::STAGE_LSB];
  assign sel_off = paddr[5:0];
  assign unmapped = (paddr[11:8] != 4'h0) || (paddr[1:0] != 2'h0);
  assign wr_en = psel && penable && pready && pwrite && !unmapped;

  always_ff @(posedge clk) begin
    if (reset) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        prdata <= (unmapped || pwrite) ? 32'h0000_0000 : stage_rd[sel_stage];
        pslverr <= unmapped;
      end
    end
  end

  // Event pending bits, one per stage and kind, set wins over clear
  logic [NS*NE-1:0] pend;
  logic [NS*NE-1:0] pend_set;
  logic [NS*NE-1:0] pend_clr;
  logic [4:0] scan;
  assign pend_clr = pend[scan] ? ((NS*NE)'(1) << scan) : '0;

  always_ff @(posedge clk) begin
    if (reset) pend <= '0;
    else pend <= (pend & ~pend_clr) | pend_set; // R15
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      scan <= '0;
      evt_valid <= 1'b0;
      evt_stage <= '0;
      evt_code <= '0;
      evt_time <= '0;
      evt_voltage <= '0;
    end else begin
      scan <= (scan == SCAN_LAST) ? 5'h00 : scan + 1'b1;
      evt_valid <= pend[scan];
      if (pend[scan]) begin
        evt_stage <= 2'(scan / 5'(NE)); // R16
        evt_code <= 3'(scan % 5'(NE));
        evt_time <= time_stamp; // R17
        evt_voltage <= measured_voltage;
      end
    end
  end

  genvar s;
  generate
    for (s = 0; s < NS; s++) begin : g_stage
      logic [4:0] cfg;
      logic [TW-1:0] dt_dly;
      logic [TW-1:0] rel_dly;
      logic [12:0] dial;
      logic [11:0] expo;
      logic [VW-1:0] thr;
      logic [NE-1:0] mask;
      logic [3:0] rec_sel;
      ovt_pkg::ovt_state_t state;
      logic [TW-1:0] opt;
      logic [TW-1:0] relc;
      logic pu;
      logic st;
      logic tr;
      logic bk;
      logic [2:0] prv;
      logic [2:0] cur;
      logic [NE-1:0] ev;
      logic next_pu;
      logic [TW-1:0] delay;
      logic [TW-1:0] opt_inc;
      logic [TW-1:0] relc_inc;
      logic [TW-1:0] remaining;
      logic [22:0] vm_pct;
      logic [22:0] thr_pct;
      logic wsel;
      // Records
      logic [2:0] rec_pend;
      logic [2:0] rec_take;
      logic [2:0] rec_code;
      logic [3:0] wr_ptr;
      logic [3:0] rec_cnt;
      logic [31:0] rec_ts [ovt_pkg::REC_DEPTH];
      logic [8:0] rec_info [ovt_pkg::REC_DEPTH];
      logic [VW-1:0] rec_v20 [ovt_pkg::REC_DEPTH];
      logic [VW-1:0] rec_vf [ovt_pkg::REC_DEPTH];
      logic [VW-1:0] rec_v200 [ovt_pkg::REC_DEPTH];
      logic [TW-1:0] rec_rem [ovt_pkg::REC_DEPTH];
      logic [3:0] rd_idx;

      assign wsel = wr_en && (sel_stage == 2'(s));
      always_ff @(posedge clk) begin
        if (reset) begin
          cfg <= ovt_pkg::CFG_RESET; // R4
          dt_dly <= ovt_pkg::DT_DEFAULT; // R5
          dial <= ovt_pkg::DIAL_DEFAULT; // R7
          expo <= ovt_pkg::EXP_DEFAULT; // R8
          rel_dly <= ovt_pkg::REL_DEFAULT; // R9
          thr <= ovt_pkg::THR_DEFAULT;
          mask <= ovt_pkg::MASK_RESET;
          rec_sel <= '0;
        end else if (wsel) begin
          case (sel_off)
            ovt_pkg::OFF_CFG: cfg <= pwdata[4:0];
            ovt_pkg::OFF_DT: dt_dly <= (pwdata[TW-1:0] > ovt_pkg::MAX_TICKS) ? ovt_pkg::MAX_TICKS : pwdata[TW-1:0];
            ovt_pkg::OFF_DIAL: dial <= pwdata[12:0];
            ovt_pkg::OFF_EXP: expo <= pwdata[11:0];
            ovt_pkg::OFF_REL: rel_dly <= pwdata[TW-1:0];
            ovt_pkg::OFF_THR: thr <= pwdata[VW-1:0];
            ovt_pkg::OFF_MASK: mask <= pwdata[NE-1:0];
            ovt_pkg::OFF_RSEL: rec_sel <= (pwdata[3:0] >= 4'(ovt_pkg::REC_DEPTH)) ? 4'h0 : pwdata[3:0];
            default: ;
          endcase
        end
      end

      assign vm_pct = 23'(measured_voltage) * 23'(ovt_pkg::PCT_FULL);
      assign thr_pct = 23'(thr) * 23'(ovt_pkg::PCT_RESET);
      assign next_pu = pu ? (vm_pct >= thr_pct) : (measured_voltage > thr); // R21
      assign delay = (cfg[ovt_pkg::CFG_TYPE_LSB +: 2] == ovt_pkg::DLY_INVERSE) ?
                     inverse_delay_mode_ticks(measured_voltage, thr, dial, expo) : dt_dly; // R3
      assign opt_inc = (opt == ovt_pkg::MAX_TICKS) ? opt : opt + 1'b1;
      assign relc_inc = relc + 1'b1;
      assign remaining = (delay > opt) ? delay - opt : '0; // R24

      always_ff @(posedge clk) begin
        if (reset) begin
          state <= ovt_pkg::ST_IDLE;
          opt <= '0;
          relc <= '0;
          pu <= 1'b0;
          st <= 1'b0;
          tr <= 1'b0;
          bk <= 1'b0;
        end else if (tick) begin // R23
          pu <= next_pu;
          bk <= next_pu && blocking_in[s]; // R22
          if (next_pu && !blocking_in[s]) begin
            state <= ovt_pkg::ST_RUN;
            st <= 1'b1;
            relc <= '0;
            opt <= opt_inc; // R2
            tr <= (opt_inc >= delay); // R1 R6 R13
          end else begin
            tr <= 1'b0;
            case (state)
              ovt_pkg::ST_RUN: begin
                relc <= '0;
                if (cfg[ovt_pkg::CFG_DREL] || cfg[ovt_pkg::CFG_TRST]) begin
                  state <= ovt_pkg::ST_REL;
                  st <= cfg[ovt_pkg::CFG_DREL]; // R10
                  if (!cfg[ovt_pkg::CFG_TRST]) opt <= '0; // R11
                  else if (cfg[ovt_pkg::CFG_CONT]) opt <= opt_inc; // R12
                end else begin
                  state <= ovt_pkg::ST_IDLE;
                  st <= 1'b0; // R10
                  opt <= '0; // R11
                end
              end
              ovt_pkg::ST_REL: begin
                if (cfg[ovt_pkg::CFG_CONT] && cfg[ovt_pkg::CFG_TRST]) opt <= opt_inc; // R12
                if (relc_inc >= rel_dly) begin // R9
                  state <= ovt_pkg::ST_IDLE;
                  st <= 1'b0;
                  opt <= '0; // R11
                  relc <= '0;
                end else begin
                  relc <= relc_inc;
                end
              end
              default: begin
                state <= ovt_pkg::ST_IDLE;
                st <= 1'b0;
                opt <= '0;
                relc <= '0;
              end
            endcase
          end
        end
      end

      assign start_out[s] = st;
      assign trip_out[s] = tr;
      assign blocked_out[s] = bk;

      // Status edges: start, trip, blocked
      assign cur = {bk, tr, st};
      always_ff @(posedge clk) begin
        if (reset) prv <= '0;
        else prv <= cur;
      end
      assign ev = {prv[2] & ~cur[2], cur[2] & ~prv[2], prv[1] & ~cur[1], cur[1] & ~prv[1],
                   prv[0] & ~cur[0], cur[0] & ~prv[0]}; // R14
      assign pend_set[s*NE +: NE] = ev & mask; // R15 R16

      // Record writer, one ON event per cycle, lowest kind first
      assign rec_take = rec_pend & ~(rec_pend - 3'h1);
      assign rec_code = rec_take[0] ? 3'h0 : (rec_take[1] ? 3'h2 : 3'h4);
      always_ff @(posedge clk) begin
        if (reset) rec_pend <= '0;
        else rec_pend <= (rec_pend & ~rec_take) | {ev[4], ev[2], ev[0]}; // R19
      end
      always_ff @(posedge clk) begin
        if (reset) begin
          wr_ptr <= '0;
          rec_cnt <= '0;
        end else if (rec_take != 3'h0) begin
          wr_ptr <= (wr_ptr == 4'(ovt_pkg::REC_DEPTH - 1)) ? 4'h0 : wr_ptr + 1'b1; // R18
          if (rec_cnt != 4'(ovt_pkg::REC_DEPTH)) rec_cnt <= rec_cnt + 1'b1;
        end
      end
      always_ff @(posedge clk) begin
        if (rec_take != 3'h0) begin
          rec_ts[wr_ptr] <= time_stamp; // R20
          rec_info[wr_ptr] <= {setting_group, fault_type, rec_code};
          rec_v20[wr_ptr] <= avg_pre;
          rec_vf[wr_ptr] <= measured_voltage;
          rec_v200[wr_ptr] <= hist[ovt_pkg::HIST_DEPTH - 1];
          rec_rem[wr_ptr] <= remaining;
        end
      end

      assign rd_idx = rec_sel;
      always_comb begin
        case (sel_off)
          ovt_pkg::OFF_CFG: stage_rd[s] = 32'(cfg);
          ovt_pkg::OFF_DT: stage_rd[s] = 32'(dt_dly);
          ovt_pkg::OFF_DIAL: stage_rd[s] = 32'(dial);
          ovt_pkg::OFF_EXP: stage_rd[s] = 32'(expo);
          ovt_pkg::OFF_REL: stage_rd[s] = 32'(rel_dly);
          ovt_pkg::OFF_THR: stage_rd[s] = 32'(thr);
          ovt_pkg::OFF_MASK: stage_rd[s] = 32'(mask);
          ovt_pkg::OFF_STAT: stage_rd[s] = 32'({rec_cnt, wr_ptr, state, pu, bk, tr, st});
          ovt_pkg::OFF_REM: stage_rd[s] = 32'(remaining);
          ovt_pkg::OFF_RSEL: stage_rd[s] = 32'(rec_sel);
          ovt_pkg::OFF_RTS: stage_rd[s] = rec_ts[rd_idx];
          ovt_pkg::OFF_RINFO: stage_rd[s] = 32'(rec_info[rd_idx]);
          ovt_pkg::OFF_RV20: stage_rd[s] = 32'(rec_v20[rd_idx]);
          ovt_pkg::OFF_RVF: stage_rd[s] = 32'(rec_vf[rd_idx]);
          ovt_pkg::OFF_RV200: stage_rd[s] = 32'(rec_v200[rd_idx]);
          ovt_pkg::OFF_RREM: stage_rd[s] = 32'(rec_rem[rd_idx]);
          default: stage_rd[s] = 32'h0000_0000;
        endcase
      end
    end
  endgenerate
endmodule : ovt_timing
`default_nettype wire

// ===== include/ovt_pkg.sv
`default_nettype none
package ovt_pkg;
  // Program-cycle tick
  localparam int CLK_MHZ = 25;
  localparam int TICK_US = 5000;
  localparam int TICK_MS = 5;
  localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
  localparam int TCW = 17;

  localparam int NUM_STAGES = 4;
  localparam int EVT_KINDS = 6;
  localparam int REC_DEPTH = 12;
  localparam int VW = 16;
  localparam int TW = 20;

  // Voltage history for pre-trigger and pre-fault values
  localparam int PRE_TRIG_MS = 20;
  localparam int PRE_FAULT_MS = 200;
  localparam int AVG_DEPTH = PRE_TRIG_MS / TICK_MS;
  localparam int HIST_DEPTH = PRE_FAULT_MS / TICK_MS;
  localparam int AVG_SHIFT = 2;

  // Delay settings, in ms, with DT_DEFAULT, REL_DEFAULT and MAX_TICKS converted to ticks
  localparam int DT_DEFAULT_MS = 40;
  localparam int REL_DEFAULT_MS = 60;
  localparam int MAX_DELAY_MS = 1800000;
  localparam logic [TW-1:0] DT_DEFAULT = TW'(DT_DEFAULT_MS / TICK_MS);
  localparam logic [TW-1:0] REL_DEFAULT = TW'(REL_DEFAULT_MS / TICK_MS);
  localparam logic [TW-1:0] MAX_TICKS = TW'(MAX_DELAY_MS / TICK_MS);
  localparam int DIAL_STEP_MS = 10;
  localparam int DIAL_TICKS = DIAL_STEP_MS / TICK_MS;
  localparam logic [12:0] DIAL_DEFAULT = 13'h0005;
  localparam logic [11:0] EXP_DEFAULT = 12'h064;
  localparam int EXP_SCALE = 100;
  localparam int RATIO_FRAC = 12;

  // Pick-up hysteresis
  localparam int PCT_FULL = 100;
  localparam int PCT_RESET = 97;
  localparam logic [VW-1:0] THR_DEFAULT = 16'h1000;

  localparam logic [1:0] DLY_FIXED = 2'h1;
  localparam logic [1:0] DLY_INVERSE = 2'h2;

  // Configuration word fields
  localparam int CFG_TYPE_LSB = 0;
  localparam int CFG_DREL = 2;
  localparam int CFG_TRST = 3;
  localparam int CFG_CONT = 4;
  localparam logic [4:0] CFG_RESET = 5'h0D;
  localparam logic [EVT_KINDS-1:0] MASK_RESET = 6'h3F;

  // Register map: one 64-byte window per stage
  localparam int STAGE_LSB = 6;
  localparam logic [5:0] OFF_CFG = 6'h00;
  localparam logic [5:0] OFF_DT = 6'h04;
  localparam logic [5:0] OFF_DIAL = 6'h08;
  localparam logic [5:0] OFF_EXP = 6'h0C;
  localparam logic [5:0] OFF_REL = 6'h10;
  localparam logic [5:0] OFF_THR = 6'h14;
  localparam logic [5:0] OFF_MASK = 6'h18;
  localparam logic [5:0] OFF_STAT = 6'h1C;
  localparam logic [5:0] OFF_REM = 6'h20;
  localparam logic [5:0] OFF_RSEL = 6'h24;
  localparam logic [5:0] OFF_RTS = 6'h28;
  localparam logic [5:0] OFF_RINFO = 6'h2C;
  localparam logic [5:0] OFF_RV20 = 6'h30;
  localparam logic [5:0] OFF_RVF = 6'h34;
  localparam logic [5:0] OFF_RV200 = 6'h38;
  localparam logic [5:0] OFF_RREM = 6'h3C;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_REL = 2'b10
  } ovt_state_t;
endpackage : ovt_pkg
`default_nettype wire

// ===== verif/ovt_source.sv
`timescale 1ns/1ps
`default_nettype none
module ovt_source (
  input wire logic clk,
  input wire logic reset,
  input wire logic [15:0] volt_cmd,
  input wire logic [3:0] block_cmd,
  output logic [15:0] measured_voltage,
  output logic [3:0] blocking_in,
  output logic [31:0] time_stamp,
  output logic [2:0] fault_type,
  output logic [2:0] setting_group
);
  always_ff @(posedge clk) begin
    if (reset) begin
      measured_voltage <= 16'h0000;
      blocking_in <= 4'h0;
      time_stamp <= 32'h00000000;
      fault_type <= 3'h0;
      setting_group <= 3'h0;
    end else begin
      measured_voltage <= volt_cmd;
      blocking_in <= block_cmd;
      time_stamp <= time_stamp + 32'h00000001;
      fault_type <= 3'h1;
      setting_group <= 3'h2;
    end
  end
endmodule : ovt_source
`default_nettype wire

// ===== verif/ovt_timing_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ovt_timing_properties #(
  parameter int TICK_CYCLES = 20
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] start_out,
  input wire logic [3:0] trip_out,
  input wire logic evt_valid,
  input wire logic [1:0] evt_stage,
  input wire logic [2:0] evt_code,
  input wire logic [31:0] evt_time
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  ready_wait_a: assert property (psel && penable && !pready |=> pready) else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
  addr_err_a: assert property (pready |-> pslverr == (paddr[11:8] != 4'h0 || paddr[1:0] != 2'h0))
    else $error("pslverr wrong");
  err_zero_a: assert property (pslverr |-> prdata == 32'h0) else $error("prdata not zero on error");
  start_hold_a: assert property (!$stable(start_out) |=> $stable(start_out)[*8])
    else $error("start moved between ticks");
  trip_hold_a: assert property (!$stable(trip_out) |=> $stable(trip_out)[*8])
    else $error("trip moved between ticks");
  start_on_evt_a: assert property ($rose(start_out[0]) |-> ##[1:26] evt_valid && evt_stage == 2'h0 && evt_code == 3'h0)
    else $error("start on event missing");
  start_off_evt_a: assert property ($fell(start_out[0]) |-> ##[1:26] evt_valid && evt_stage == 2'h0 && evt_code == 3'h1)
    else $error("start off event missing");
  trip_on_evt_a: assert property ($rose(trip_out[0]) |-> ##[1:26] evt_valid && evt_stage == 2'h0 && evt_code == 3'h2)
    else $error("trip on event missing");
  evt_hold_a: assert property (!evt_valid |-> $stable(evt_time) && $stable(evt_code))
    else $error("event fields changed without valid");
endmodule : ovt_timing_properties
bind ovt_timing ovt_timing_properties #(.TICK_CYCLES(TICK_CYCLES)) u_ovt_props (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .start_out(start_out), .trip_out(trip_out),
  .evt_valid(evt_valid), .evt_stage(evt_stage), .evt_code(evt_code), .evt_time(evt_time)
);
`default_nettype wire

// ===== verif/ovt_timing_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ovt_timing_tb_top;
  localparam int TICK = 20;
  logic clk, reset, psel, penable, pwrite, pready, pslverr, evt_valid, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, time_stamp, evt_time, rd;
  logic [15:0] volt_cmd, measured_voltage, evt_voltage, last_v;
  logic [3:0] block_cmd, blocking_in, start_out, trip_out, blocked_out;
  logic [2:0] fault_type, setting_group, evt_code;
  logic [1:0] evt_stage;
  int failures, cmp_count, cyc, t0, t1, st3_rises, trip_rises;
  int ev_cnt[4];

  ovt_timing #(.TICK_CYCLES(TICK)) dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .measured_voltage(measured_voltage), .blocking_in(blocking_in), .time_stamp(time_stamp),
    .fault_type(fault_type), .setting_group(setting_group), .start_out(start_out), .trip_out(trip_out),
    .blocked_out(blocked_out), .evt_valid(evt_valid), .evt_stage(evt_stage), .evt_code(evt_code),
    .evt_time(evt_time), .evt_voltage(evt_voltage));
  ovt_source u_src (.clk(clk), .reset(reset), .volt_cmd(volt_cmd), .block_cmd(block_cmd),
    .measured_voltage(measured_voltage), .blocking_in(blocking_in), .time_stamp(time_stamp),
    .fault_type(fault_type), .setting_group(setting_group));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (evt_valid === 1'b1) ev_cnt[evt_stage] <= ev_cnt[evt_stage] + 1;
    if (evt_valid === 1'b1 && evt_stage == 2'h0 && evt_code == 3'h0) last_v <= evt_voltage;
  end
  always @(posedge start_out[3]) st3_rises++;
  always @(posedge trip_out[0]) trip_rises++;

  task wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    chk("pready", 32'h1, {31'h0, pready});
  endtask : apb

  task rdc(input string name, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(name, e, rd);
  endtask : rdc

  task drive(input logic [15:0] v, input logic [3:0] b);
    @(posedge clk);
    volt_cmd <= v; block_cmd <= b;
  endtask : drive

  // Kind 0 start, 1 trip, 2 blocked; returns cycle of the change
  task wait_out(input int kind, input int st, input logic lvl, output int t);
    int n;
    logic v;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      v = (kind == 0) ? start_out[st] : (kind == 1) ? trip_out[st] : blocked_out[st];
      n++;
    end while (v !== lvl && n < 2000);
    t = cyc;
    chk("output level", {31'h0, lvl}, {31'h0, v});
  endtask : wait_out

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    wrap_up;
  end

  initial begin
    reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    volt_cmd = 16'h0000; block_cmd = 4'h0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rdc("cfg", 12'h000, 32'h0D);
    rdc("fixed delay", 12'h004, 32'h8);
    rdc("dial", 12'h008, 32'h5);
    rdc("exponent", 12'h00C, 32'h64);
    rdc("release", 12'h010, 32'hC);
    rdc("mask", 12'h018, 32'h3F);
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    apb(1'b0, 12'h002, 32'h0);
    chk("misaligned err", 32'h1, {31'h0, er});
    apb(1'b1, 12'h01C, 32'hFFFF);
    rdc("status", 12'h01C, 32'h0);
    apb(1'b1, 12'h098, 32'h0);
    apb(1'b1, 12'h0D8, 32'h1);
    apb(1'b1, 12'h000, 32'h1D);
    $display("test defaults done");
    drive(16'h1200, 4'h0);
    wait_out(0, 0, 1'b1, t0);
    drive(16'h0F00, 4'h0);
    wait_out(0, 0, 1'b0, t1);
    chk("held start", 32'((1 + 12) * TICK), 32'(t1 - t0));
    chk("trip in release", 32'h0, 32'(trip_rises));
    apb(1'b1, 12'h024, 32'h0);
    rdc("record info", 12'h02C, 32'h88);
    $display("test delayed release done");
    apb(1'b1, 12'h000, 32'h09);
    drive(16'h1200, 4'h0);
    wait_out(0, 0, 1'b1, t0);
    drive(16'h0F00, 4'h0);
    wait_out(0, 0, 1'b0, t1);
    chk("quick drop", 32'(TICK), 32'(t1 - t0));
    $display("test quick release done");
    apb(1'b1, 12'h000, 32'h0D);
    drive(16'h1200, 4'h0);
    wait_out(0, 0, 1'b1, t0);
    wait_out(1, 0, 1'b1, t1);
    // Timer still holds one tick from the cut pick-up, release not yet expired
    chk("fixed trip", 32'(6 * TICK), 32'(t1 - t0));
    apb(1'b1, 12'h024, 32'h3);
    rdc("record trip", 12'h02C, 32'h8A);
    rdc("record avg", 12'h030, 32'h1200);
    rdc("record voltage", 12'h034, 32'h1200);
    drive(16'h0000, 4'h0);
    wait_out(1, 0, 1'b0, t1);
    wait_out(0, 0, 1'b0, t1);
    $display("test fixed delay done");
    apb(1'b1, 12'h004, 32'h0);
    drive(16'h1200, 4'h0);
    wait_out(0, 0, 1'b1, t0);
    chk("instant trip", 32'h1, {31'h0, trip_out[0]});
    drive(16'h0000, 4'h0);
    wait_out(1, 0, 1'b0, t1);
    wait_out(0, 0, 1'b0, t1);
    $display("test instant done");
    apb(1'b1, 12'h000, 32'h0E);
    apb(1'b1, 12'h008, 32'hA);
    drive(16'h2000, 4'h0);
    wait_out(0, 0, 1'b1, t0);
    wait_out(1, 0, 1'b1, t1);
    chk("inverse trip", 32'(19 * TICK), 32'(t1 - t0));
    rdc("remaining", 12'h020, 32'h0);
    chk("event voltage", 32'h2000, 32'(last_v));
    drive(16'h0000, 4'h0);
    wait_out(1, 0, 1'b0, t1);
    wait_out(0, 0, 1'b0, t1);
    wait_out(0, 1, 1'b0, t1);
    $display("test inverse done");
    drive(16'h1200, 4'h2);
    wait_out(2, 1, 1'b1, t0);
    chk("blocked start", 32'h0, {31'h0, start_out[1]});
    drive(16'h0000, 4'h0);
    wait_out(2, 1, 1'b0, t1);
    repeat (40) @(posedge clk);
    chk("masked events", 32'h0, 32'(ev_cnt[2]));
    chk("start rises", 32'h5, 32'(st3_rises));
    chk("start on events", 32'h5, 32'(ev_cnt[3]));
    $display("test blocking and masks done");
    wrap_up;
  end
endmodule : ovt_timing_tb_top
`default_nettype wire
